// ---- hw/cas_regs.svh ----
// Holding register indices, field positions, limits and reset values
// of the cascade configuration bank; definitions only.
// Assumes the includer uses 16-bit protocol indices.
`ifndef CAS_REGS_SVH
`define CAS_REGS_SVH

// Protocol indices of the holding registers
`define CAS_IDX_OP_SWITCH    16'h022B
`define CAS_IDX_DEMAND_SRC   16'h022C
`define CAS_IDX_SETPT_SEL    16'h022D
`define CAS_IDX_MOD_SENSOR   16'h022E
`define CAS_IDX_BACKUP       16'h022F
`define CAS_IDX_LOW_TEMP     16'h0230
`define CAS_IDX_HIGH_TEMP    16'h0231
`define CAS_IDX_REMOTE_SETPT 16'h0232
`define CAS_IDX_HEAT_CALL    16'h0233
`define CAS_IDX_SEL_MODE     16'h0234
`define CAS_IDX_CMD_WORD     16'h0235
`define CAS_IDX_BASE_RATE    16'h0236
`define CAS_IDX_IDLE_FAN     16'h0237
`define CAS_IDX_SEQ_POS      16'h0238
`define CAS_IDX_PORT         16'h0239
`define CAS_IDX_FIRE_DELAY   16'h023A
`define CAS_IDX_CAPACITY     16'h023B
`define CAS_IDX_SHARED_BASE  16'h023C
`define CAS_IDX_RATE_METHOD  16'h023D
`define CAS_REG_COUNT        19

// Command word bit positions
`define CAS_CMD_DEMAND       15
`define CAS_CMD_SUSPEND      14
`define CAS_CMD_FAN          13
`define CAS_CMD_PUMP_X       12
`define CAS_CMD_PUMP_Y       11
`define CAS_CMD_PUMP_Z       10
`define CAS_CMD_PUMP_DEMAND  9
`define CAS_CMD_FRACTION     8

// Value limits
`define CAS_TEMP_MIN         16'hFE70
`define CAS_TEMP_MAX         16'h0514
`define CAS_DELAY_MAX        16'hFD20
`define CAS_NOT_CONFIGURED   16'hFFFF
`define CAS_SHARED_MIN       16'h000A
`define CAS_SHARED_MAX       16'h03E8
`define CAS_SEQ_MAX          16'h00FF

// Reset values and exception codes
`define CAS_RESET_VALUE      16'h0000
`define CAS_EXC_ADDRESS      8'h02
`define CAS_EXC_VALUE        8'h03

`endif

// ---- hw/cas_pkg.sv ----
// Types shared by the cascade configuration bank and its users.
// Assumes nothing beyond a SystemVerilog compiler.
package cas_pkg;

  // Decoded demand source
  typedef enum logic [2:0] {DEM_OFF, DEM_TERMINAL, DEM_REMOTE, DEM_SERIAL, DEM_EITHER} cas_demand_e;
  // Setpoint source
  typedef enum logic [1:0] {SP_LOCAL, SP_SERIAL, SP_ANALOG} cas_setpt_e;
  // Backup modulation sensor
  typedef enum logic [1:0] {BK_NONE, BK_LEAD_OUTLET, BK_AVG_OUTLET} cas_backup_e;
  // Follower selection mode
  typedef enum logic [1:0] {FM_FIRST, FM_EQUALIZE, FM_LAST} cas_mode_e;
  // Serial port used for cascade control
  typedef enum logic [1:0] {PT_NONE, PT_LOCAL_SERIAL_PORT, PT_GLOBAL_SERIAL_PORT} cas_port_e;

  // Register access request from the protocol engine
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [15:0] wdata;
  } cas_req_s;

  // Answer to one request
  typedef struct packed {
    logic        valid;
    logic        error;
    logic [7:0]  code;
    logic [15:0] rdata;
  } cas_rsp_s;

  // Fields of the follower command word
  typedef struct packed {
    logic       demand_req;
    logic       suspend;
    logic       fan_req;
    logic       pump_x;
    logic       pump_y;
    logic       pump_z;
    logic       pump_demand;
    logic       rate_fraction;
    logic [7:0] rate;
  } cas_cmd_s;

  // Decoded configuration for the cascade logic
  typedef struct packed {
    logic        cascade_run;
    cas_demand_e demand_src;
    logic        heat_call_active;
    cas_setpt_e  setpt_src;
    logic [15:0] active_setpoint;
    logic        use_tenth_sensor_input;
    cas_backup_e backup;
    logic [15:0] low_temp;
    logic [15:0] high_temp;
    cas_mode_e   mode;
    cas_cmd_s    cmd;
    logic [15:0] base_rate;
    logic [15:0] idle_fan_rate;
    logic [7:0]  seq_pos;
    cas_port_e   port;
    logic        delay_configured;
    logic [15:0] delay_secs;
    logic [15:0] capacity;
    logic        shared_enabled;
    logic [15:0] shared_rate;
    logic        parallel_limited;
  } cas_cfg_s;

endpackage

// ---- hw/cas_config_bank.sv ----
// Cascade configuration holding register bank with decoded outputs.
// Assumes a protocol engine in front that presents one request at a time
// and waits for the answer; all inputs are synchronous to core_clk.
`timescale 1ns/100ps
`include "cas_regs.svh"

module cas_config_bank
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // Register access from the protocol engine
  input  wire cas_pkg::cas_req_s req,
  output      cas_pkg::cas_rsp_s rsp,
  // Demand and setpoint sources outside the bank
  input  wire logic             terminal_call,
  input  wire logic             remote_call,
  input  wire logic [15:0]      local_setpoint,
  input  wire logic [15:0]      analog_setpoint,
  // Decoded configuration
  output      cas_pkg::cas_cfg_s cfg
);

  // Holding register storage, one word per index
  logic [15:0] bank [0:`CAS_REG_COUNT-1];

  // Slot of a protocol index inside the bank
  function automatic logic [4:0] slot_of(input logic [15:0] idx);
    logic [15:0] diff;
    diff = idx - `CAS_IDX_OP_SWITCH;
    slot_of = diff[4:0];
  endfunction

  // Reset value of a slot; the delay starts unset
  function automatic logic [15:0] reset_of(input logic [4:0] slot);
    reset_of = (slot == slot_of(`CAS_IDX_FIRE_DELAY)) ? `CAS_NOT_CONFIGURED
                                                      : `CAS_RESET_VALUE;
  endfunction

  // Signed temperature range check in tenths of a degree
  function automatic logic temp_ok(input logic [15:0] d);
    temp_ok = ($signed(d) >= $signed(`CAS_TEMP_MIN)) &&
              ($signed(d) <= $signed(`CAS_TEMP_MAX));
  endfunction

  // Value legality per register; a refused write leaves the word alone
  // so downstream logic never sees an encoding it cannot decode
  function automatic logic value_ok(input logic [15:0] idx, input logic [15:0] d);
    case (idx)
      `CAS_IDX_OP_SWITCH:    value_ok = d <= 16'h0001;
      `CAS_IDX_DEMAND_SRC:   value_ok = (d <= 16'h0006) &&
                                        (d != 16'h0002) && (d != 16'h0005);
      `CAS_IDX_SETPT_SEL:    value_ok = d <= 16'h0002;
      `CAS_IDX_MOD_SENSOR:   value_ok = d <= 16'h0001;
      `CAS_IDX_BACKUP:       value_ok = d <= 16'h0002;
      `CAS_IDX_LOW_TEMP:     value_ok = temp_ok(d);
      `CAS_IDX_HIGH_TEMP:    value_ok = temp_ok(d);
      `CAS_IDX_REMOTE_SETPT: value_ok = temp_ok(d);
      `CAS_IDX_HEAT_CALL:    value_ok = d <= 16'h0001;
      `CAS_IDX_SEL_MODE:     value_ok = d <= 16'h0002;
      `CAS_IDX_SEQ_POS:      value_ok = d <= `CAS_SEQ_MAX;
      `CAS_IDX_PORT:         value_ok = d <= 16'h0002;
      `CAS_IDX_FIRE_DELAY:   value_ok = (d <= `CAS_DELAY_MAX) ||
                                        (d == `CAS_NOT_CONFIGURED);
      `CAS_IDX_SHARED_BASE:  value_ok = (d == 16'h0000) ||
                                        ((d >= `CAS_SHARED_MIN) &&
                                         (d <= `CAS_SHARED_MAX));
      `CAS_IDX_RATE_METHOD:  value_ok = d == 16'h0000;
      // Command word, base and idle fan rates and capacity take any halfword
      default:               value_ok = 1'b1;
    endcase
  endfunction

  // Address decode of the current request
  wire       idx_hit  = (req.index >= `CAS_IDX_OP_SWITCH) &&
                        (req.index <= `CAS_IDX_RATE_METHOD);
  wire [4:0] req_slot = slot_of(req.index);
  wire       wr_ok    = value_ok(req.index, req.wdata);
  wire       do_write = req.valid && req.write && idx_hit && wr_ok;

  // Named views of the stored words
  wire [15:0] r_op     = bank[slot_of(`CAS_IDX_OP_SWITCH)];
  wire [15:0] r_demand = bank[slot_of(`CAS_IDX_DEMAND_SRC)];
  wire [15:0] r_setsel = bank[slot_of(`CAS_IDX_SETPT_SEL)];
  wire [15:0] r_remote = bank[slot_of(`CAS_IDX_REMOTE_SETPT)];
  wire [15:0] r_call   = bank[slot_of(`CAS_IDX_HEAT_CALL)];
  wire [15:0] r_cmd    = bank[slot_of(`CAS_IDX_CMD_WORD)];
  wire [15:0] r_delay  = bank[slot_of(`CAS_IDX_FIRE_DELAY)];
  wire [15:0] r_shared = bank[slot_of(`CAS_IDX_SHARED_BASE)];

  // Demand source decode
  cas_pkg::cas_demand_e next_demand;
  always_comb
  begin
    case (r_demand)
      16'h0001: next_demand = cas_pkg::DEM_TERMINAL;
      16'h0003: next_demand = cas_pkg::DEM_REMOTE;
      16'h0004: next_demand = cas_pkg::DEM_SERIAL;
      16'h0006: next_demand = cas_pkg::DEM_EITHER;
      default:  next_demand = cas_pkg::DEM_OFF;
    endcase
  end

  // Heat demand follows the chosen source, gated by the operation switch
  wire serial_call = (r_call == 16'h0001);
  wire next_call   = (r_op == 16'h0001) &&
                     ((next_demand == cas_pkg::DEM_TERMINAL && terminal_call) ||
                      (next_demand == cas_pkg::DEM_REMOTE   && remote_call)   ||
                      (next_demand == cas_pkg::DEM_SERIAL   && serial_call)   ||
                      (next_demand == cas_pkg::DEM_EITHER   &&
                       (terminal_call || remote_call)));

  // Setpoint selection
  wire cas_pkg::cas_setpt_e next_setsel =
    (r_setsel == 16'h0001) ? cas_pkg::SP_SERIAL :
    (r_setsel == 16'h0002) ? cas_pkg::SP_ANALOG : cas_pkg::SP_LOCAL;
  wire [15:0] next_setpoint =
    (next_setsel == cas_pkg::SP_SERIAL) ? r_remote :
    (next_setsel == cas_pkg::SP_ANALOG) ? analog_setpoint : local_setpoint;

  // Sensor, mode and port decode
  wire [15:0] r_backup = bank[slot_of(`CAS_IDX_BACKUP)];
  wire [15:0] r_mode   = bank[slot_of(`CAS_IDX_SEL_MODE)];
  wire [15:0] r_port   = bank[slot_of(`CAS_IDX_PORT)];
  wire cas_pkg::cas_backup_e next_backup =
    (r_backup == 16'h0001) ? cas_pkg::BK_LEAD_OUTLET :
    (r_backup == 16'h0002) ? cas_pkg::BK_AVG_OUTLET : cas_pkg::BK_NONE;
  wire cas_pkg::cas_mode_e next_mode =
    (r_mode == 16'h0001) ? cas_pkg::FM_EQUALIZE :
    (r_mode == 16'h0002) ? cas_pkg::FM_LAST : cas_pkg::FM_FIRST;
  wire cas_pkg::cas_port_e next_port =
    (r_port == 16'h0001) ? cas_pkg::PT_LOCAL_SERIAL_PORT :
    (r_port == 16'h0002) ? cas_pkg::PT_GLOBAL_SERIAL_PORT : cas_pkg::PT_NONE;

  // Command word split into its fields
  cas_pkg::cas_cmd_s next_cmd;
  assign next_cmd.demand_req    = r_cmd[`CAS_CMD_DEMAND];
  assign next_cmd.suspend       = r_cmd[`CAS_CMD_SUSPEND];
  assign next_cmd.fan_req       = r_cmd[`CAS_CMD_FAN];
  assign next_cmd.pump_x        = r_cmd[`CAS_CMD_PUMP_X];
  assign next_cmd.pump_y        = r_cmd[`CAS_CMD_PUMP_Y];
  assign next_cmd.pump_z        = r_cmd[`CAS_CMD_PUMP_Z];
  assign next_cmd.pump_demand   = r_cmd[`CAS_CMD_PUMP_DEMAND];
  assign next_cmd.rate_fraction = r_cmd[`CAS_CMD_FRACTION];
  assign next_cmd.rate          = r_cmd[7:0];

  // Whole decoded configuration, registered below
  cas_pkg::cas_cfg_s next_cfg;
  always_comb
  begin
    next_cfg                        = '0;
    next_cfg.cascade_run            = (r_op == 16'h0001);
    next_cfg.demand_src             = next_demand;
    next_cfg.heat_call_active       = next_call;
    next_cfg.setpt_src              = next_setsel;
    next_cfg.active_setpoint        = next_setpoint;
    next_cfg.use_tenth_sensor_input =
      (bank[slot_of(`CAS_IDX_MOD_SENSOR)] == 16'h0001);
    next_cfg.backup                 = next_backup;
    next_cfg.low_temp               = bank[slot_of(`CAS_IDX_LOW_TEMP)];
    next_cfg.high_temp              = bank[slot_of(`CAS_IDX_HIGH_TEMP)];
    next_cfg.mode                   = next_mode;
    next_cfg.cmd                    = next_cmd;
    next_cfg.base_rate              = bank[slot_of(`CAS_IDX_BASE_RATE)];
    next_cfg.idle_fan_rate          = bank[slot_of(`CAS_IDX_IDLE_FAN)];
    next_cfg.seq_pos                = bank[slot_of(`CAS_IDX_SEQ_POS)][7:0];
    next_cfg.port                   = next_port;
    // An unset delay is reported as such and the count reads as zero
    next_cfg.delay_configured       = (r_delay != `CAS_NOT_CONFIGURED);
    next_cfg.delay_secs             = next_cfg.delay_configured ? r_delay : 16'h0000;
    next_cfg.capacity               = bank[slot_of(`CAS_IDX_CAPACITY)];
    next_cfg.shared_enabled         = (r_shared != 16'h0000);
    next_cfg.shared_rate            = r_shared;
    next_cfg.parallel_limited       =
      (bank[slot_of(`CAS_IDX_RATE_METHOD)] == 16'h0000);
  end

  // Answer to the current request, settled one cycle later
  cas_pkg::cas_rsp_s next_rsp;
  always_comb
  begin
    next_rsp       = '0;
    next_rsp.valid = req.valid;
    if (req.valid && !idx_hit)
    begin
      // Outside the bank: illegal address exception
      next_rsp.error = 1'b1;
      next_rsp.code  = `CAS_EXC_ADDRESS;
    end
    else if (req.valid && req.write && !wr_ok)
    begin
      // Value outside the documented set: illegal value exception
      next_rsp.error = 1'b1;
      next_rsp.code  = `CAS_EXC_VALUE;
    end
    else if (req.valid && req.write)
    begin
      // A write echoes the stored value
      next_rsp.rdata = req.wdata;
    end
    else if (req.valid)
    begin
      next_rsp.rdata = bank[req_slot];
    end
  end

  // Storage update; reads have no side effects
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < `CAS_REG_COUNT; i++)
    begin
      if (reset)
        bank[i] <= reset_of(5'(i));
      else if (do_write && req_slot == 5'(i))
        bank[i] <= req.wdata;
    end
  end

  // Output flops
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rsp <= '0;
      cfg <= '0;
    end
    else
    begin
      rsp <= next_rsp;
      cfg <= next_cfg;
    end
  end

  // Unmapped index answers an address exception next cycle
  a_unmapped_refused: assert property (@(posedge core_clk) disable iff (reset)
    req.valid && !idx_hit |=> rsp.valid && rsp.error && rsp.code == `CAS_EXC_ADDRESS)
    else $error("unmapped index not refused");

  // Legal sequence position is stored and answered without error
  a_seq_store: assert property (@(posedge core_clk) disable iff (reset)
    req.valid && req.write && req.index == `CAS_IDX_SEQ_POS && req.wdata <= `CAS_SEQ_MAX
    |=> bank[slot_of(`CAS_IDX_SEQ_POS)] == $past(req.wdata) && !rsp.error)
    else $error("sequence position not stored");

  // Oversized sequence position is refused and leaves the word alone
  a_seq_refuse: assert property (@(posedge core_clk) disable iff (reset)
    req.valid && req.write && req.index == `CAS_IDX_SEQ_POS && req.wdata > `CAS_SEQ_MAX
    |=> rsp.error && rsp.code == `CAS_EXC_VALUE && $stable(bank[slot_of(`CAS_IDX_SEQ_POS)]))
    else $error("bad sequence position accepted");

  // Reserved demand encodings are refused
  a_demand_reserved: assert property (@(posedge core_clk) disable iff (reset)
    req.valid && req.write && req.index == `CAS_IDX_DEMAND_SRC &&
    (req.wdata == 16'h0002 || req.wdata == 16'h0005) |=> rsp.error)
    else $error("reserved demand code accepted");

  // Serial heat call with serial source and cascade on raises demand
  a_serial_call: assert property (@(posedge core_clk) disable iff (reset)
    r_op == 16'h0001 && r_demand == 16'h0004 && r_call == 16'h0001 |=> cfg.heat_call_active)
    else $error("serial heat call lost");

  // Operation switch off stops the cascade run and the heat demand
  a_op_stop: assert property (@(posedge core_clk) disable iff (reset)
    r_op == 16'h0000 |=> !cfg.cascade_run && !cfg.heat_call_active)
    else $error("cascade runs while switched off");

  // Serial setpoint source passes the stored setpoint
  a_setpt_serial: assert property (@(posedge core_clk) disable iff (reset)
    r_setsel == 16'h0001 |=> cfg.active_setpoint == $past(r_remote))
    else $error("serial setpoint not selected");

  // Command word fields track the stored word
  a_cmd_fields: assert property (@(posedge core_clk) disable iff (reset)
    ##1 cfg.cmd.rate == $past(r_cmd[7:0]) &&
    cfg.cmd.rate_fraction == $past(r_cmd[`CAS_CMD_FRACTION]) &&
    cfg.cmd.demand_req == $past(r_cmd[`CAS_CMD_DEMAND]))
    else $error("command fields wrong");

  // Pump bits land on the right pumps
  a_cmd_pumps: assert property (@(posedge core_clk) disable iff (reset)
    ##1 {cfg.cmd.pump_x, cfg.cmd.pump_y, cfg.cmd.pump_z} == $past(r_cmd[12:10]))
    else $error("pump bits misrouted");

  // Unset delay is flagged
  a_delay_unset: assert property (@(posedge core_clk) disable iff (reset)
    r_delay == `CAS_NOT_CONFIGURED |=> !cfg.delay_configured && cfg.delay_secs == 16'h0000)
    else $error("unset delay not flagged");

  // Out-of-range low end temperature is refused
  a_temp_range: assert property (@(posedge core_clk) disable iff (reset)
    req.valid && req.write && req.index == `CAS_IDX_LOW_TEMP && !temp_ok(req.wdata)
    |=> rsp.error && rsp.code == `CAS_EXC_VALUE)
    else $error("bad temperature accepted");

  // Out-of-range high end temperature is refused
  a_high_temp_range: assert property (@(posedge core_clk) disable iff (reset)
    req.valid && req.write && req.index == `CAS_IDX_HIGH_TEMP && !temp_ok(req.wdata)
    |=> rsp.error && rsp.code == `CAS_EXC_VALUE)
    else $error("bad high temperature accepted");

  // Out-of-range remote setpoint is refused
  a_remote_range: assert property (@(posedge core_clk) disable iff (reset)
    req.valid && req.write && req.index == `CAS_IDX_REMOTE_SETPT && !temp_ok(req.wdata)
    |=> rsp.error && rsp.code == `CAS_EXC_VALUE)
    else $error("bad remote setpoint accepted");

  // Combined demand code decodes to either source
  a_demand_either: assert property (@(posedge core_clk) disable iff (reset)
    r_demand == 16'h0006 |=> cfg.demand_src == cas_pkg::DEM_EITHER)
    else $error("combined demand code lost");

  // Sensor code one picks the tenth input
  a_sensor_select: assert property (@(posedge core_clk) disable iff (reset)
    bank[slot_of(`CAS_IDX_MOD_SENSOR)] == 16'h0001 |=> cfg.use_tenth_sensor_input)
    else $error("tenth sensor input not selected");

  // Backup code two picks the average outlet
  a_backup_avg: assert property (@(posedge core_clk) disable iff (reset)
    r_backup == 16'h0002 |=> cfg.backup == cas_pkg::BK_AVG_OUTLET)
    else $error("average outlet backup lost");

  // Mode code two picks use-last
  a_mode_last: assert property (@(posedge core_clk) disable iff (reset)
    r_mode == 16'h0002 |=> cfg.mode == cas_pkg::FM_LAST)
    else $error("use-last mode lost");

  // Suspend, fan and pump demand bits follow the word
  a_cmd_upper: assert property (@(posedge core_clk) disable iff (reset)
    ##1 {cfg.cmd.suspend, cfg.cmd.fan_req} == $past(r_cmd[14:13]) &&
    cfg.cmd.pump_demand == $past(r_cmd[`CAS_CMD_PUMP_DEMAND]))
    else $error("upper command bits wrong");

  // Base load rate passes through untouched
  a_base_copy: assert property (@(posedge core_clk) disable iff (reset)
    ##1 cfg.base_rate == $past(bank[slot_of(`CAS_IDX_BASE_RATE)]))
    else $error("base rate not passed");

  // Port code two picks the global serial port
  a_port_global: assert property (@(posedge core_clk) disable iff (reset)
    r_port == 16'h0002 |=> cfg.port == cas_pkg::PT_GLOBAL_SERIAL_PORT)
    else $error("global serial port lost");

  // Delay beyond the limit, other than unset, is refused
  a_delay_refuse: assert property (@(posedge core_clk) disable iff (reset)
    req.valid && req.write && req.index == `CAS_IDX_FIRE_DELAY &&
    req.wdata > `CAS_DELAY_MAX && req.wdata != `CAS_NOT_CONFIGURED |=> rsp.error)
    else $error("bad delay accepted");

  // Shared rate below one percent but not zero is refused
  a_shared_refuse: assert property (@(posedge core_clk) disable iff (reset)
    req.valid && req.write && req.index == `CAS_IDX_SHARED_BASE &&
    req.wdata != 16'h0000 && req.wdata < `CAS_SHARED_MIN |=> rsp.error)
    else $error("bad shared rate accepted");

  // A mapped read returns the stored word
  a_read_back: assert property (@(posedge core_clk) disable iff (reset)
    req.valid && !req.write && idx_hit |=> !rsp.error && rsp.rdata == $past(bank[req_slot]))
    else $error("read data wrong");

endmodule

// ---- sim/cas_master_model.sv ----
// Master model for the register port of the cascade bank.
// Assumes the bank registers its answer on the edge that takes a request.
`timescale 1ns/100ps

module cas_master_model
(
  // Clock
  input  wire logic              core_clk,
  // Register port
  output      cas_pkg::cas_req_s req,
  input  wire cas_pkg::cas_rsp_s rsp
);
  // Port idle from time zero
  initial req = '0;

  // One request: raised after an edge, held to the taking edge, answer taken after it
  task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                        output cas_pkg::cas_rsp_s got);
    @(posedge core_clk);
    // Whole request travels as one unit
    req <= '{valid: 1'b1, write: wr, index: idx, wdata: wd};
    @(posedge core_clk);
    // Released lines show the inverse, so a stale value never passes for a live one
    req <= '{valid: 1'b0, write: ~wr, index: ~idx, wdata: ~wd};
    #1 got = rsp;
  endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the cascade configuration bank.
// Assumes the bank, its header and package, and the master model.
`timescale 1ns/100ps
`include "cas_regs.svh"

module tb;
  // Design connections
  logic                 core_clk;
  logic                 reset;
  cas_pkg::cas_req_s    req;
  cas_pkg::cas_rsp_s    rsp;
  logic                 terminal_call;
  logic                 remote_call;
  logic [15:0]          local_setpoint;
  logic [15:0]          analog_setpoint;
  cas_pkg::cas_cfg_s    cfg;
  // Run counters
  int                   failures = 0;
  int                   check_count = 0;
  int                   cycles = 0;
  // Legal value per index, a limit value where the register has one, operation switch first
  logic [15:0]          good [19] = '{16'h0001, 16'h0006, 16'h0002, 16'h0001, 16'h0002,
    16'hFE70, 16'h0514, 16'h0514, 16'h0001, 16'h0002, 16'hA5C3, 16'h1234, 16'h0F0F,
    16'h00FF, 16'h0002, 16'hFD20, 16'h7FFF, 16'h03E8, 16'h0000};
  // Refused writes: index offset and illegal value
  int                   bad_off [15] = '{0, 1, 1, 2, 3, 4, 5, 6, 8, 9, 13, 14, 15, 17, 18};
  logic [15:0]          bad_val [15] = '{16'h0002, 16'h0002, 16'h0005, 16'h0003, 16'h0002,
    16'h0003, 16'hFE6F, 16'h0515, 16'h0002, 16'h0003, 16'h0100, 16'h0003, 16'hFD21,
    16'h0009, 16'h0001};
  // Demand codes and their decoded sources
  logic [15:0]          dem_code [5] = '{16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0006};
  cas_pkg::cas_demand_e dem_src [5] = '{cas_pkg::DEM_OFF, cas_pkg::DEM_TERMINAL,
    cas_pkg::DEM_REMOTE, cas_pkg::DEM_SERIAL, cas_pkg::DEM_EITHER};
  // Setpoints: local input, remote register, analog input
  logic [15:0]          sp [3] = '{16'h0111, 16'h0514, 16'h0222};

  cas_config_bank uut (.core_clk(core_clk), .reset(reset), .req(req), .rsp(rsp),
    .terminal_call(terminal_call), .remote_call(remote_call),
    .local_setpoint(local_setpoint), .analog_setpoint(analog_setpoint), .cfg(cfg));

  cas_master_model master (.core_clk(core_clk), .req(req), .rsp(rsp));

  // 100 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      failures++;
      $display("wrong value at %0t: run timed out", $time);
      final_report();
    end
  end

  // Protocol index of an offset from the operation switch
  function automatic logic [15:0] ix(input int i);
    return 16'(`CAS_IDX_OP_SWITCH + i);
  endfunction

  // One comparison
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One transfer with its answer judged
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                      input logic [7:0] code, input logic [15:0] exp);
    cas_pkg::cas_rsp_s got;
    master.access(wr, idx, wd, got);
    check(16'(got.valid), 16'h0001, "answer");
    check(16'(got.error), 16'(code != 8'h00), "error");
    check(16'(got.code), 16'(code), "code");
    check(got.rdata, exp, "data");
  endtask

  // Legal write, then wait the edge that moves it into cfg
  task automatic wr_cfg(input logic [15:0] idx, input logic [15:0] v);
    xfer(1'b1, idx, v, 8'h00, v);
    @(posedge core_clk);
    #1;
  endtask

  task automatic t_reset();
    for (int i = 0; i < 19; i++)
      xfer(1'b0, ix(i), 16'h0000, 8'h00, (i == 15) ? 16'hFFFF : 16'h0000);
    $display("test reset values done");
  endtask

  task automatic t_legal();
    for (int i = 0; i < 19; i++)
    begin
      xfer(1'b1, ix(i), good[i], 8'h00, good[i]);
      xfer(1'b0, ix(i), 16'h0000, 8'h00, good[i]);
    end
    @(posedge core_clk);
    #1;
    check(16'(cfg.cascade_run), 16'h0001, "run");
    check(16'(cfg.use_tenth_sensor_input), 16'h0001, "sensor");
    check(16'(cfg.backup), 16'(cas_pkg::BK_AVG_OUTLET), "backup");
    check(cfg.low_temp, 16'hFE70, "low temp");
    check(cfg.high_temp, 16'h0514, "high temp");
    check(16'(cfg.mode), 16'(cas_pkg::FM_LAST), "mode");
    check(16'(cfg.cmd), 16'hA5C3, "command");
    check(cfg.idle_fan_rate, 16'h0F0F, "idle fan");
    check(cfg.base_rate, 16'h1234, "base rate");
    check(16'(cfg.port), 16'(cas_pkg::PT_GLOBAL_SERIAL_PORT), "port");
    check(cfg.delay_secs, 16'hFD20, "delay");
    check(cfg.capacity, 16'h7FFF, "capacity");
    check(cfg.shared_rate, 16'h03E8, "shared");
    check(16'(cfg.parallel_limited), 16'h0001, "method");
    check(16'(cfg.seq_pos), 16'h00FF, "sequence");
    $display("test legal writes done");
  endtask

  // Illegal values leave the bank alone; unmapped indices refused
  task automatic t_refuse();
    for (int i = 0; i < 15; i++)
    begin
      xfer(1'b1, ix(bad_off[i]), bad_val[i], `CAS_EXC_VALUE, 16'h0000);
      xfer(1'b0, ix(bad_off[i]), 16'h0000, 8'h00, good[bad_off[i]]);
    end
    xfer(1'b1, ix(7), 16'h8000, `CAS_EXC_VALUE, 16'h0000);
    xfer(1'b0, 16'h022A, 16'h0000, `CAS_EXC_ADDRESS, 16'h0000);
    xfer(1'b1, 16'h023E, 16'h0001, `CAS_EXC_ADDRESS, 16'h0000);
    $display("test refused requests done");
  endtask

  task automatic t_decode();
    logic exp;
    wr_cfg(`CAS_IDX_OP_SWITCH, 16'h0000);
    terminal_call <= 1'b1;
    wr_cfg(`CAS_IDX_DEMAND_SRC, 16'h0006);
    check(16'(cfg.heat_call_active), 16'h0000, "stopped");
    wr_cfg(`CAS_IDX_OP_SWITCH, 16'h0001);
    // Each demand code against each single call source
    for (int c = 0; c < 5; c++)
      for (int s = 0; s < 3; s++)
      begin
        terminal_call <= (s == 0);
        remote_call <= (s == 1);
        wr_cfg(`CAS_IDX_HEAT_CALL, 16'(s == 2));
        wr_cfg(`CAS_IDX_DEMAND_SRC, dem_code[c]);
        exp = (c == 1 && s == 0) || (c == 2 && s == 1);
        exp = exp || (c == 3 && s == 2) || (c == 4 && s < 2);
        check(16'(cfg.heat_call_active), 16'(exp), "heat call");
        check(16'(cfg.demand_src), 16'(dem_src[c]), "source");
      end
    for (int p = 0; p < 3; p++)
    begin
      wr_cfg(`CAS_IDX_SETPT_SEL, 16'(p));
      check(cfg.active_setpoint, sp[p], "setpoint");
      check(16'(cfg.setpt_src), 16'(p), "setpoint source");
    end
    wr_cfg(`CAS_IDX_FIRE_DELAY, `CAS_NOT_CONFIGURED);
    check(16'(cfg.delay_configured), 16'h0000, "delay unset");
    wr_cfg(`CAS_IDX_SHARED_BASE, 16'h0000);
    check(16'(cfg.shared_enabled), 16'h0000, "shared off");
    wr_cfg(`CAS_IDX_CMD_WORD, 16'h5A3C);
    check(16'(cfg.cmd), 16'h5A3C, "command");
    $display("test decode done");
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    reset = 1'b1;
    terminal_call = 1'b0;
    remote_call = 1'b0;
    local_setpoint = sp[0];
    analog_setpoint = sp[2];
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_legal();
    t_refuse();
    t_decode();
    final_report();
  end
endmodule
